//--- hw/t1_datalink_src_and_framing_ctrl.sv
`timescale 1ns/1ns
`include "t1dl_defs.svh"
module t1_datalink_src_and_framing_ctrl
  import t1dl_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [13:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        tx_dl_slot,
  input  wire logic        lapd1_dl_bit,
  output logic             lapd1_dl_req,
  input  wire logic        tx_serial_in,
  input  wire logic        tx_overhead_in,
  output logic             tx_dl_bit,
  output logic             tx_dl_bit_valid,
  input  wire logic        rx_fbit_valid,
  input  wire logic        rx_fbit_error,
  input  wire logic        rx_align_found,
  input  wire logic        rx_crc_ok,
  input  wire logic        rx_crc_error,
  output logic             in_frame,
  output logic             lof_defect,
  output logic             irq
);

  logic          ack_r;
  logic          req;
  logic [11:0]   idx;
  logic          wr_lo;
  logic          rd_done;
  logic [31:0]   readdata_r;

  dl_src_t       tx_dl_src_r;
  logic          reframe_r;
  logic          crc_en_r;
  logic [2:0]    tol_r;
  logic [2:0]    rng_r;
  logic [1:0]    int_status_r;
  logic [1:0]    int_mask_r;

  logic          ser_s1_r;
  logic          ser_s2_r;
  logic          oh_s1_r;
  logic          oh_s2_r;
  logic          tx_dl_bit_r;
  logic          tx_dl_valid_r;

  framer_state_t state_r;
  framer_state_t state_nxt;
  logic          in_frame_r;
  logic          lof_defect_r;
  logic          lof_hit;
  logic          reframe_rise;
  logic          sync_event;
  logic          lof_declare;
  logic [1:0]    events;

  // Avalon-MM slave, one wait cycle on every access
  assign req         = read | write;
  assign waitrequest = req & ~ack_r;
  assign idx         = address[13:2];
  assign wr_lo       = write & ack_r & byteenable[0];
  assign rd_done     = read & ack_r;
  assign readdata    = readdata_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      readdata_r <= 32'h0;
    end else if (read && !ack_r) begin
      case (idx)
        `IDX_TX_DL_SELECT:  readdata_r <= {30'h0, tx_dl_src_r};
        `IDX_FRAMING_CTRL:  readdata_r <= {24'h0, reframe_r, crc_en_r, tol_r, rng_r};
        `IDX_INT_STATUS:    readdata_r <= {30'h0, int_status_r};
        `IDX_INT_MASK:      readdata_r <= {30'h0, int_mask_r};
        `IDX_FRAMER_STATUS: readdata_r <= {28'h0, lof_defect_r, in_frame_r, state_r};
        default:            readdata_r <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_dl_src_r <= dl_src_t'(`TX_DL_SRC_RST);
    end else if (wr_lo && idx == `IDX_TX_DL_SELECT) begin
      tx_dl_src_r <= dl_src_t'(writedata[`TX_DL_SRC_MSB:`TX_DL_SRC_LSB]);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      crc_en_r <= `FC_CRC_EN_RST;
      tol_r    <= `FC_TOL_RST;
      rng_r    <= `FC_RNG_RST;
    end else if (wr_lo && idx == `IDX_FRAMING_CTRL) begin
      crc_en_r <= writedata[`FC_CRC_EN_BIT];
      tol_r    <= writedata[`FC_TOL_MSB:`FC_TOL_LSB];
      rng_r    <= writedata[`FC_RNG_MSB:`FC_RNG_LSB];
    end
  end

  assign reframe_rise = wr_lo && (idx == `IDX_FRAMING_CTRL) &&
                        writedata[`FC_REFRAME_BIT] && !reframe_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reframe_r <= `FC_REFRAME_RST;
    end else if (wr_lo && idx == `IDX_FRAMING_CTRL) begin
      reframe_r <= writedata[`FC_REFRAME_BIT];
    end else if (sync_event) begin
      reframe_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      int_mask_r <= `INT_MASK_RST;
    end else if (wr_lo && idx == `IDX_INT_MASK) begin
      int_mask_r <= writedata[1:0];
    end
  end

  // Sticky events, read clears only what was reported, new events win
  assign events = {sync_event, lof_declare};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      int_status_r <= `INT_STATUS_RST;
    end else if (rd_done && idx == `IDX_INT_STATUS) begin
      int_status_r <= (int_status_r & ~readdata_r[1:0]) | events;
    end else begin
      int_status_r <= int_status_r | events;
    end
  end

  assign irq = |(int_status_r & int_mask_r);

  // Pin synchronisers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ser_s1_r <= 1'b0;
      ser_s2_r <= 1'b0;
      oh_s1_r  <= 1'b0;
      oh_s2_r  <= 1'b0;
    end else begin
      ser_s1_r <= tx_serial_in;
      ser_s2_r <= ser_s1_r;
      oh_s1_r  <= tx_overhead_in;
      oh_s2_r  <= oh_s1_r;
    end
  end

  assign lapd1_dl_req = tx_dl_slot && (tx_dl_src_r == DL_SRC_LAPD1);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_dl_bit_r   <= 1'b1;
      tx_dl_valid_r <= 1'b0;
    end else begin
      tx_dl_valid_r <= tx_dl_slot;
      if (tx_dl_slot) begin
        case (tx_dl_src_r)
          DL_SRC_LAPD1:    tx_dl_bit_r <= lapd1_dl_bit;
          DL_SRC_SERIAL:   tx_dl_bit_r <= ser_s2_r;
          DL_SRC_OVERHEAD: tx_dl_bit_r <= oh_s2_r;
          DL_SRC_ONES:     tx_dl_bit_r <= 1'b1;
          default:         tx_dl_bit_r <= 1'b1;
        endcase
      end
    end
  end

  assign tx_dl_bit       = tx_dl_bit_r;
  assign tx_dl_bit_valid = tx_dl_valid_r;

  lof_window #(
    .DEPTH(`LOF_WIN_DEPTH)
  ) u_lof_window (
    .clock           (clock),
    .rst_n           (rst_n),
    .clear           (state_r != FR_IN_FRAME),
    .fbit_valid      (rx_fbit_valid),
    .fbit_error      (rx_fbit_error),
    .error_threshold (tol_r),
    .window_size     (rng_r),
    .lof_hit         (lof_hit)
  );

  // Receive framer alignment state
  always_comb begin
    state_nxt = state_r;
    if (reframe_rise) begin
      state_nxt = FR_SEARCH;
    end else begin
      case (state_r)
        FR_SEARCH: begin
          if (rx_align_found) begin
            state_nxt = crc_en_r ? FR_CRC_WAIT : FR_IN_FRAME;
          end
        end
        FR_CRC_WAIT: begin
          if (rx_crc_error) begin
            state_nxt = FR_SEARCH;
          end else if (rx_crc_ok) begin
            state_nxt = FR_IN_FRAME;
          end
        end
        FR_IN_FRAME: begin
          if (lof_hit) begin
            state_nxt = FR_SEARCH;
          end
        end
        default: state_nxt = FR_SEARCH;
      endcase
    end
  end

  assign sync_event  = (state_r != FR_IN_FRAME) && (state_nxt == FR_IN_FRAME);
  assign lof_declare = (state_r == FR_IN_FRAME) && lof_hit && !reframe_rise;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r    <= FR_SEARCH;
      in_frame_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      in_frame_r <= (state_nxt == FR_IN_FRAME);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lof_defect_r <= 1'b0;
    end else if (lof_declare) begin
      lof_defect_r <= 1'b1;
    end else if (sync_event) begin
      lof_defect_r <= 1'b0;
    end
  end

  assign in_frame   = in_frame_r;
  assign lof_defect = lof_defect_r;

  property p_src_lapd;
    @(posedge clock) disable iff (!rst_n)
    tx_dl_slot && tx_dl_src_r == DL_SRC_LAPD1 |=> tx_dl_bit == $past(lapd1_dl_bit);
  endproperty
  a_src_lapd: assert property (p_src_lapd) else $error("LAPD source bit wrong");

  property p_lapd_only;
    @(posedge clock) disable iff (!rst_n)
    lapd1_dl_req |-> tx_dl_slot && tx_dl_src_r == DL_SRC_LAPD1;
  endproperty
  a_lapd_only: assert property (p_lapd_only) else $error("LAPD asked off source");

  property p_src_ser;
    @(posedge clock) disable iff (!rst_n)
    tx_dl_slot && tx_dl_src_r == DL_SRC_SERIAL |=> tx_dl_bit == $past(tx_serial_in, 3);
  endproperty
  a_src_ser: assert property (p_src_ser) else $error("Serial source bit wrong");

  property p_src_oh;
    @(posedge clock) disable iff (!rst_n)
    tx_dl_slot && tx_dl_src_r == DL_SRC_OVERHEAD |=> tx_dl_bit == $past(tx_overhead_in, 3);
  endproperty
  a_src_oh: assert property (p_src_oh) else $error("Overhead source bit wrong");

  property p_src_ones;
    @(posedge clock) disable iff (!rst_n)
    tx_dl_slot && tx_dl_src_r == DL_SRC_ONES |=> tx_dl_bit && tx_dl_bit_valid;
  endproperty
  a_src_ones: assert property (p_src_ones) else $error("Forced ones missing");

  property p_rst_vals;
    @(posedge clock)
    !rst_n |=> tx_dl_src_r == DL_SRC_LAPD1 && crc_en_r && tol_r == 3'h0 && rng_r == 3'h3;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("Reset values wrong");

  property p_reframe;
    @(posedge clock) disable iff (!rst_n)
    reframe_rise |=> state_r == FR_SEARCH && !in_frame ##1 !in_frame;
  endproperty
  a_reframe: assert property (p_reframe) else $error("Reframe did not restart");

  property p_autoclr;
    @(posedge clock) disable iff (!rst_n)
    sync_event && !(wr_lo && idx == `IDX_FRAMING_CTRL) |=> !reframe_r && in_frame;
  endproperty
  a_autoclr: assert property (p_autoclr) else $error("Reframe not cleared");

  property p_crc_wait;
    @(posedge clock) disable iff (!rst_n)
    state_r == FR_SEARCH && rx_align_found && crc_en_r && !reframe_rise
    |=> state_r == FR_CRC_WAIT && !in_frame;
  endproperty
  a_crc_wait: assert property (p_crc_wait) else $error("CRC step skipped");

  property p_no_crc;
    @(posedge clock) disable iff (!rst_n)
    state_r == FR_SEARCH && rx_align_found && !crc_en_r && !reframe_rise |=> in_frame;
  endproperty
  a_no_crc: assert property (p_no_crc) else $error("Alignment alone ignored");

  property p_lof;
    @(posedge clock) disable iff (!rst_n)
    lof_declare |=> lof_defect && !in_frame && state_r == FR_SEARCH;
  endproperty
  a_lof: assert property (p_lof) else $error("Loss of frame not declared");

  property p_tol_block;
    @(posedge clock) disable iff (!rst_n)
    tol_r == 3'h0 && !lof_defect |=> !lof_defect;
  endproperty
  a_tol_block: assert property (p_tol_block) else $error("Zero threshold not blocked");

  property p_rng_block;
    @(posedge clock) disable iff (!rst_n)
    rng_r == 3'h0 && !lof_defect |=> !lof_defect;
  endproperty
  a_rng_block: assert property (p_rng_block) else $error("Zero window not blocked");

  property p_window;
    @(posedge clock) disable iff (!rst_n)
    state_r == FR_IN_FRAME && tol_r == 3'h1 && rng_r != 3'h0 && rx_fbit_valid && rx_fbit_error
    |=> lof_hit;
  endproperty
  a_window: assert property (p_window) else $error("Window missed error");

  property p_bus_wait;
    @(posedge clock) disable iff (!rst_n)
    $rose(req) |-> waitrequest ##1 !waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("Bus wait timing wrong");

endmodule

//--- common/t1dl_defs.svh
`ifndef T1DL_DEFS_SVH
`define T1DL_DEFS_SVH

// Register indices, byte address is four times the index
`define IDX_TX_DL_SELECT    12'h10a
`define IDX_FRAMING_CTRL    12'h10b
`define IDX_INT_STATUS      12'h110
`define IDX_INT_MASK        12'h111
`define IDX_FRAMER_STATUS   12'h112

// Field positions
`define TX_DL_SRC_MSB       1
`define TX_DL_SRC_LSB       0
`define FC_REFRAME_BIT      7
`define FC_CRC_EN_BIT       6
`define FC_TOL_MSB          5
`define FC_TOL_LSB          3
`define FC_RNG_MSB          2
`define FC_RNG_LSB          0
`define INT_LOF_BIT         0
`define INT_SYNC_BIT        1

// Reset values
`define TX_DL_SRC_RST       2'h0
`define FC_REFRAME_RST      1'h0
`define FC_CRC_EN_RST       1'h1
`define FC_TOL_RST          3'h0
`define FC_RNG_RST          3'h3
`define INT_STATUS_RST      2'h0
`define INT_MASK_RST        2'h0

// Longest loss-of-frame window in framing bits
`define LOF_WIN_DEPTH       7
`endif

//--- common/t1dl_pkg.sv
package t1dl_pkg;
  typedef enum logic [1:0] {
    FR_SEARCH   = 2'b00,
    FR_CRC_WAIT = 2'b01,
    FR_IN_FRAME = 2'b11
  } framer_state_t;

  typedef enum logic [1:0] {
    DL_SRC_LAPD1    = 2'b00,
    DL_SRC_SERIAL   = 2'b01,
    DL_SRC_OVERHEAD = 2'b10,
    DL_SRC_ONES     = 2'b11
  } dl_src_t;
endpackage

//--- hw/lof_window.sv
`timescale 1ns/1ns
module lof_window #(
  parameter int DEPTH = 7
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       fbit_valid,
  input  wire logic       fbit_error,
  input  wire logic [2:0] error_threshold,
  input  wire logic [2:0] window_size,
  output logic            lof_hit
);
  logic [DEPTH-1:0] hist_r;
  logic [3:0]       err_cnt;

  always_ff @(posedge clock) begin
    if (!rst_n || clear) begin
      hist_r <= '0;
    end else if (fbit_valid) begin
      hist_r <= {hist_r[DEPTH-2:0], fbit_error};
    end
  end

  always_comb begin
    err_cnt = 4'h0;
    for (int i = 0; i < DEPTH; i++) begin
      if ((i < int'(window_size)) && hist_r[i]) begin
        err_cnt = err_cnt + 4'h1;
      end
    end
  end

  assign lof_hit = (error_threshold != 3'h0) && (window_size != 3'h0) &&
                   (err_cnt >= {1'b0, error_threshold});
endmodule

//--- test/t1dl_line_model.sv
`timescale 1ns/1ns
module t1dl_line_model (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic lapd1_dl_req,
  output logic      tx_dl_slot,
  output logic      lapd1_dl_bit,
  output logic      tx_serial_in,
  output logic      tx_overhead_in
);
  logic [3:0] ph;

  initial begin
    ph = 4'h0;
    tx_dl_slot = 1'b0;
    lapd1_dl_bit = 1'b0;
    tx_serial_in = 1'b0;
    tx_overhead_in = 1'b0;
  end

  // Pins move half a period away from the slot, so the synchroniser settles
  always @(posedge clock) begin
    ph <= rst_n ? ph + 4'h1 : 4'h0;
    tx_dl_slot <= rst_n && ph == 4'h7;
    if (ph == 4'hf) begin
      tx_serial_in <= 1'($urandom);
      tx_overhead_in <= 1'($urandom);
    end
    // Next controller bit offered only after a pop
    if (lapd1_dl_req) begin
      lapd1_dl_bit <= 1'($urandom);
    end
  end
endmodule

//--- test/t1_datalink_src_and_framing_ctrl_tb_top.sv
`timescale 1ns/1ns
module t1_datalink_src_and_framing_ctrl_tb_top
  import t1dl_pkg::*;
;
  logic          clock, rst_n, read, write, waitrequest, irq;
  logic [13:0]   address;
  logic [31:0]   writedata, readdata, m_rd;
  logic [3:0]    byteenable;
  logic          tx_dl_slot, lapd1_dl_bit, lapd1_dl_req, tx_serial_in, tx_overhead_in;
  logic          tx_dl_bit, tx_dl_bit_valid, in_frame, lof_defect;
  logic          rx_fbit_valid, rx_fbit_error, rx_align_found, rx_crc_ok, rx_crc_error;
  logic [11:0]   idx;
  dl_src_t       m_src;
  framer_state_t m_st, pst;
  logic [7:0]    m_fc, d;
  logic [2:0]    thr, win;
  logic [1:0]    m_sts, m_msk;
  logic          m_lof, m_txv, m_txb, wr_ok, rf, crc, m_ack;
  int            hist[$];
  int            c, r, cyc, err_count, n_compared;

  assign idx = address[13:2];

  t1_datalink_src_and_framing_ctrl i_dut (.clock(clock), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .tx_dl_slot(tx_dl_slot),
    .lapd1_dl_bit(lapd1_dl_bit), .lapd1_dl_req(lapd1_dl_req), .tx_serial_in(tx_serial_in),
    .tx_overhead_in(tx_overhead_in), .tx_dl_bit(tx_dl_bit), .tx_dl_bit_valid(tx_dl_bit_valid),
    .rx_fbit_valid(rx_fbit_valid), .rx_fbit_error(rx_fbit_error),
    .rx_align_found(rx_align_found), .rx_crc_ok(rx_crc_ok), .rx_crc_error(rx_crc_error),
    .in_frame(in_frame), .lof_defect(lof_defect), .irq(irq));

  t1dl_line_model i_line (.clock(clock), .rst_n(rst_n), .lapd1_dl_req(lapd1_dl_req),
    .tx_dl_slot(tx_dl_slot), .lapd1_dl_bit(lapd1_dl_bit), .tx_serial_in(tx_serial_in),
    .tx_overhead_in(tx_overhead_in));

  task give_verdict();
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task bus(input logic w, input logic [11:0] i, input logic [7:0] dat, input logic [3:0] be);
    @(posedge clock);
    address <= {i, 2'h0};
    writedata <= {24'h0, dat};
    byteenable <= be;
    read <= !w;
    write <= w;
    do @(posedge clock); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task wr(input logic [11:0] i, input logic [7:0] dat);
    bus(1'b1, i, dat, 4'h1);
  endtask

  task rd(input logic [11:0] i);
    bus(1'b0, i, 8'h00, 4'h1);
  endtask

  // Strobe order: fbit valid, fbit error, align, crc ok, crc error
  task strobe(input logic [4:0] s);
    @(posedge clock);
    {rx_fbit_valid, rx_fbit_error, rx_align_found, rx_crc_ok, rx_crc_error} <= s;
    @(posedge clock);
    {rx_fbit_valid, rx_fbit_error, rx_align_found, rx_crc_ok, rx_crc_error} <= 5'h00;
  endtask

  function logic [31:0] regval(input logic [11:0] i);
    case (i)
      12'h10a: regval = {30'h0, m_src};
      12'h10b: regval = {24'h0, m_fc};
      12'h110: regval = {30'h0, m_sts};
      12'h111: regval = {30'h0, m_msk};
      12'h112: regval = {28'h0, m_lof, m_st == FR_IN_FRAME, m_st};
      default: regval = 32'h0;
    endcase
  endfunction

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // Reference model, compared at every edge
  always @(posedge clock) begin
    if (!rst_n) begin
      m_src = DL_SRC_LAPD1;
      m_fc = 8'h43;
      m_st = FR_SEARCH;
      m_lof = 1'b0;
      m_sts = 2'h0;
      m_msk = 2'h0;
      m_txv = 1'b0;
      m_txb = 1'b1;
      m_ack = 1'b0;
      hist = {};
    end else begin
      chk("in_frame", m_st == FR_IN_FRAME, in_frame);
      chk("lof_defect", m_lof, lof_defect);
      chk("irq", |(m_sts & m_msk), irq);
      chk("lapd1_dl_req", tx_dl_slot && m_src == DL_SRC_LAPD1, lapd1_dl_req);
      chk("tx_dl_bit_valid", m_txv, tx_dl_bit_valid);
      chk("tx_dl_bit", m_txb, tx_dl_bit);
      chk("waitrequest", (read || write) && !m_ack, waitrequest);
      if (read && !m_ack) begin
        m_rd = regval(idx);
      end
      if (read && m_ack) begin
        chk("readdata", m_rd, readdata);
        if (idx == 12'h110) begin
          m_sts = m_sts & ~m_rd[1:0];
        end
      end
      m_txv = tx_dl_slot;
      if (tx_dl_slot) begin
        case (m_src)
          DL_SRC_LAPD1:    m_txb = lapd1_dl_bit;
          DL_SRC_SERIAL:   m_txb = tx_serial_in;
          DL_SRC_OVERHEAD: m_txb = tx_overhead_in;
          default:         m_txb = 1'b1;
        endcase
      end
      wr_ok = write && m_ack && byteenable[0];
      rf = wr_ok && idx == 12'h10b && writedata[7] && !m_fc[7];
      crc = m_fc[6];
      thr = m_fc[5:3];
      win = m_fc[2:0];
      pst = m_st;
      if (wr_ok && idx == 12'h10a) begin
        m_src = dl_src_t'(writedata[1:0]);
      end
      if (wr_ok && idx == 12'h10b) begin
        m_fc = writedata[7:0];
      end
      if (wr_ok && idx == 12'h111) begin
        m_msk = writedata[1:0];
      end
      if (rf) begin
        m_st = FR_SEARCH;
        hist = {};
      end else if (pst == FR_SEARCH && rx_align_found) begin
        m_st = crc ? FR_CRC_WAIT : FR_IN_FRAME;
      end else if (pst == FR_CRC_WAIT && rx_crc_error) begin
        m_st = FR_SEARCH;
      end else if (pst == FR_CRC_WAIT && rx_crc_ok) begin
        m_st = FR_IN_FRAME;
      end else if (pst == FR_IN_FRAME) begin
        c = 0;
        for (int i = 0; i < win && i < hist.size(); i++) begin
          c += hist[i];
        end
        if (thr != 3'h0 && win != 3'h0 && c >= thr) begin
          m_st = FR_SEARCH;
          m_lof = 1'b1;
          m_sts[0] = 1'b1;
        end
      end
      // Window history is kept only while in frame, newest first
      if (pst != FR_IN_FRAME) begin
        hist = {};
      end else if (rx_fbit_valid) begin
        hist.push_front(int'(rx_fbit_error));
        if (hist.size() > 7) begin
          void'(hist.pop_back());
        end
      end
      if (m_st == FR_IN_FRAME && pst != FR_IN_FRAME) begin
        m_lof = 1'b0;
        m_sts[1] = 1'b1;
        if (!(wr_ok && idx == 12'h10b)) begin
          m_fc[7] = 1'b0;
        end
      end
      m_ack = (read || write) && !m_ack;
    end
  end

  initial begin
    {rst_n, read, write, address, writedata, byteenable} = '0;
    {rx_fbit_valid, rx_fbit_error, rx_align_found, rx_crc_ok, rx_crc_error} = 5'h00;
    r = $urandom(23511);
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    // Reset values, then an unmapped place
    rd(12'h10a);
    rd(12'h10b);
    rd(12'h110);
    rd(12'h111);
    rd(12'h112);
    rd(12'h1ff);
    wr(12'h1ff, 8'hff);
    bus(1'b1, 12'h10a, 8'h02, 4'h0);
    wr(12'h10a, 8'hff);
    rd(12'h10a);
    rd(12'h1ff);
    // Every data link source in turn
    for (int s = 0; s < 4; s++) begin
      wr(12'h10a, 8'(s));
      repeat (64) @(posedge clock);
    end
    wr(12'h111, 8'h03);
    strobe(5'h04);
    strobe(5'h01);
    strobe(5'h04);
    strobe(5'h02);
    rd(12'h110);
    wr(12'h10b, 8'h15);
    // Two errors five bits apart miss a window of five; the next one hits
    for (int k = 0; k < 7; k++) begin
      strobe({1'b1, 7'b1000011 >> (6 - k) & 7'h1 ? 1'b1 : 1'b0, 3'h0});
    end
    rd(12'h110);
    for (int z = 0; z < 2; z++) begin
      wr(12'h10b, z == 0 ? 8'h05 : 8'h10);
      strobe(5'h04);
      repeat (8) strobe(5'h18);
    end
    wr(12'h10b, 8'h95);
    rd(12'h10b);
    strobe(5'h04);
    rd(12'h10b);
    rd(12'h112);
    repeat (300) begin
      r = $urandom % 8;
      d = 8'($urandom);
      case (r)
        0: wr(d[0] ? 12'h10b : 12'h10a, d);
        1: strobe(5'h04);
        2: strobe(5'h02);
        3: strobe(5'h01);
        4: rd(d[1] ? 12'h110 : (d[0] ? 12'h112 : 12'h10b));
        5: wr(12'h111, d);
        default: strobe({1'b1, d[0] & d[1], 3'h0});
      endcase
    end
    give_verdict();
  end
endmodule
